// ### rtl/cbirq_pkg.sv
// Shared types and constants for the bus control and interrupt intake block
package cbirq_pkg;

	//****************************************************************
	// Widths
	//****************************************************************
	localparam int ADDR_W = 16;
	localparam int DATA_W = 8;

	//****************************************************************
	// Processor state codes on {bus_granted, state_code}
	//****************************************************************
	localparam logic [1:0] CODE_RUNNING = 2'h0;
	localparam logic [1:0] CODE_VECTOR  = 2'h1;
	localparam logic [1:0] CODE_WAIT    = 2'h2;
	localparam logic [1:0] CODE_HALT    = 2'h3;

	// Reset values of the bus pins
	localparam logic [ADDR_W-1:0] ADDR_RST = 16'hFFFF;
	localparam logic [DATA_W-1:0] DATA_RST = 8'h00;

	//****************************************************************
	// Interrupt sequence kinds handed to the core
	//****************************************************************
	typedef enum logic [2:0] {
		IRQ_NONE   = 3'b000,
		IRQ_NMI    = 3'b001,
		IRQ_FAST   = 3'b010,
		IRQ_NORMAL = 3'b011,
		IRQ_SOFT   = 3'b100
	} cbirq_kind_t;

	//****************************************************************
	// Bus cycle phase, tracked from the two sampled clock inputs
	//****************************************************************
	typedef enum logic [1:0] {
		PH_BOTH_LOW  = 2'b00,
		PH_A_HIGH    = 2'b01,
		PH_BOTH_HIGH = 2'b11,
		PH_B_ONLY    = 2'b10
	} cbirq_phase_t;

	// Status and bus requests coming from the instruction sequencer
	typedef struct packed {
		logic              instr_boundary;
		logic              last_cycle;
		logic              rmw_cycle;
		logic              first_of_pair;
		logic              first_of_vector;
		logic              multi_push_pull;
		logic              uses_bus_next;
		logic              halted;
		logic              waiting;
		logic              stacking;
		logic              vector_fetch;
		logic              stack_ptr_loaded;
		logic              quick_mask;
		logic              normal_mask;
		logic              soft_request;
		logic              write;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} cbirq_core_t;

	// Interrupt sequence order handed back to the sequencer
	typedef struct packed {
		logic        take;
		cbirq_kind_t kind;
		logic        push_full;
		logic        set_quick_mask;
		logic        set_normal_mask;
	} cbirq_take_t;

	// Status pins that keep driving while the bus floats
	typedef struct packed {
		logic       bus_granted;
		logic       state_code;
		logic       atomic_hold;
		logic       next_cycle_bus_use;
		logic       final_op_cycle;
	} cbirq_status_t;

endpackage

// ### rtl/cbirq_sync.sv
// Two-stage synchroniser for a group of asynchronous inputs
`timescale 1ns/1ns
module cbirq_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '1
) (
	input  wire logic             clk,
	input  wire logic             resetn,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] meta_d;
	logic [WIDTH-1:0] sync_q;
	logic [WIDTH-1:0] sync_d;

	// Each bit gets its own pair; first stage feeds only the second
	for (genvar i = 0; i < WIDTH; i++) begin : g_bit
		always_comb begin
			meta_d[i] = resetn ? async_in[i] : RST_VAL[i];
			sync_d[i] = resetn ? meta_q[i] : RST_VAL[i];
		end
	end

	always_ff @(posedge clk) begin
		meta_q <= meta_d;
		sync_q <= sync_d;
	end

	assign sync_out = sync_q;
endmodule

// ### rtl/cbirq_top.sv
// Bus control and hardware interrupt intake for an 8-bit processor
//
// Summary of operation
// - Falling edge on nonmaskable input raises request
// - Nonmaskable unblockable, beats all other interrupts
// - Nonmaskable sequence pushes the whole register set
// - Nonmaskable ignored until stack pointer first loaded
// - Late nonmaskable edge recognised next cycle
// - Fast low level interrupts while quick mask clear
// - Fast sequence pushes only flags and counter
// - Normal low level interrupts, full push, mask clear
// - Fast served before normal when both pending
// - Read data captured, address updated, lagging fall
// - Atomic hold on modify cycles, first pair byte
// - Atomic hold on first indirect or vector byte
// - Atomic hold never during multi push or pop
// - Bus use predicted; low when halted or waiting
// - Final cycle flag high on instruction's last cycle
// - Final cycle flag high halted at instruction boundary, waiting, stacking
// - Float releases address, data, direction; status drives
// - Float gates address early; write data from lead rise
// - Float held past lagging rise latches for cycle
// - State encoding: running, vector, wait, halt
// - Quick mask blocks fast; set by most sequences
`timescale 1ns/1ns
module cbirq_top
	import cbirq_pkg::*;
(
	input  wire logic                    clk,
	input  wire logic                    resetn,
	input  wire logic                    clk_ph_a,
	input  wire logic                    clk_ph_b,
	input  wire logic                    nonmaskable_request_n,
	input  wire logic                    fast_request_n,
	input  wire logic                    normal_request_n,
	input  wire logic                    bus_float_ctl,
	input  wire logic [cbirq_pkg::DATA_W-1:0] data_in,
	input  wire cbirq_pkg::cbirq_core_t  core,
	output cbirq_pkg::cbirq_take_t       take,
	output cbirq_pkg::cbirq_status_t     status,
	output logic [cbirq_pkg::DATA_W-1:0] read_data,
	output logic                         read_data_valid,
	output logic [cbirq_pkg::ADDR_W-1:0] addr_out,
	output logic                         addr_oe_n,
	output logic                         rd_wr_out,
	output logic                         rd_wr_oe_n,
	output logic [cbirq_pkg::DATA_W-1:0] data_out,
	output logic                         data_oe_n
);
	import cbirq_pkg::*;

	//****************************************************************
	// Pin synchronisation
	//****************************************************************
	localparam int NSYNC = 6 + DATA_W;
	localparam logic [NSYNC-1:0] SYNC_RST = {6'b111100, DATA_RST};

	logic [NSYNC-1:0] pins_s;
	logic             ph_a_s;
	logic             ph_b_s;
	logic             nmi_n_s;
	logic             fast_n_s;
	logic             normal_n_s;
	logic             float_s;
	logic [DATA_W-1:0] data_s;

	// Every pin, clocks included, passes two flip-flops first
	cbirq_sync #(
		.WIDTH   (NSYNC),
		.RST_VAL (SYNC_RST)
	) u_sync (
		.clk      (clk),
		.resetn   (resetn),
		.async_in ({nonmaskable_request_n, fast_request_n, normal_request_n,
			bus_float_ctl, clk_ph_a, clk_ph_b, data_in}),
		.sync_out (pins_s)
	);

	always_comb begin
		nmi_n_s    = pins_s[NSYNC-1];
		fast_n_s   = pins_s[NSYNC-2];
		normal_n_s = pins_s[NSYNC-3];
		float_s    = pins_s[NSYNC-4];
		ph_a_s     = pins_s[NSYNC-5];
		ph_b_s     = pins_s[NSYNC-6];
		data_s     = pins_s[DATA_W-1:0];
	end

	//****************************************************************
	// Bus cycle phase tracking
	//****************************************************************
	cbirq_phase_t phase_q;
	cbirq_phase_t phase_d;
	logic         a_rise;
	logic         b_rise;
	logic         b_fall;

	// Edges are read off the phase register so each pin edge strobes for one clock only
	always_comb begin
		phase_d = cbirq_phase_t'({ph_b_s, ph_a_s});
		a_rise  = 1'b0;
		b_rise  = 1'b0;
		b_fall  = 1'b0;
		case (phase_q)
			PH_BOTH_LOW:  a_rise = ph_a_s;
			PH_A_HIGH:    b_rise = ph_b_s;
			PH_BOTH_HIGH: b_fall = !ph_b_s;
			PH_B_ONLY:    b_fall = !ph_b_s;
			default:      a_rise = 1'b0;
		endcase
		// A lagging clock that leads is outside spec; we follow the pins
		if (!resetn) begin
			phase_d = PH_BOTH_LOW;
		end
	end

	always_ff @(posedge clk) begin
		phase_q <= phase_d;
	end

	//****************************************************************
	// Nonmaskable edge detect, arming and pending flag
	//****************************************************************
	logic nmi_prev_q;
	logic nmi_prev_d;
	logic nmi_armed_q;
	logic nmi_armed_d;
	logic nmi_pend_q;
	logic nmi_pend_d;
	logic nmi_edge;
	logic take_now;
	cbirq_kind_t pick;

	// Level sampled only at the leading clock rise, so a late edge slips a cycle
	always_comb begin
		nmi_prev_d  = nmi_prev_q;
		nmi_armed_d = nmi_armed_q;
		nmi_pend_d  = nmi_pend_q;
		nmi_edge    = 1'b0;
		if (a_rise) begin
			nmi_prev_d = nmi_n_s;
			nmi_edge   = nmi_prev_q && !nmi_n_s;
		end
		if (core.stack_ptr_loaded) begin
			nmi_armed_d = 1'b1;
		end
		if (take_now && pick == IRQ_NMI) begin
			nmi_pend_d = 1'b0;
		end
		// A fresh edge in the clearing cycle is kept
		if (nmi_edge && nmi_armed_q) begin
			nmi_pend_d = 1'b1;
		end
		if (!resetn) begin
			nmi_prev_d  = 1'b1;
			nmi_armed_d = 1'b0;
			nmi_pend_d  = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		nmi_prev_q  <= nmi_prev_d;
		nmi_armed_q <= nmi_armed_d;
		nmi_pend_q  <= nmi_pend_d;
	end

	//****************************************************************
	// Priority pick at an instruction boundary
	//****************************************************************
	cbirq_take_t take_q;
	cbirq_take_t take_d;

	// Fixed order: nonmaskable, fast, normal, software
	always_comb begin
		pick = IRQ_NONE;
		if (nmi_pend_q) begin
			pick = IRQ_NMI;
		end else if (!fast_n_s && !core.quick_mask && !core.halted) begin
			pick = IRQ_FAST;
		end else if (!normal_n_s && !core.normal_mask && !core.halted) begin
			pick = IRQ_NORMAL;
		end else if (core.soft_request) begin
			pick = IRQ_SOFT;
		end
		// Decided once per bus cycle, before the next opcode fetch
		take_now = b_fall && core.instr_boundary && (pick != IRQ_NONE);
	end

	// Sequence order with stacking extent and mask updates
	always_comb begin
		take_d = '0;
		take_d.kind = IRQ_NONE;
		if (take_now) begin
			take_d.take            = 1'b1;
			take_d.kind            = pick;
			take_d.push_full       = (pick != IRQ_FAST);
			take_d.set_quick_mask  = (pick != IRQ_NORMAL);
			take_d.set_normal_mask = 1'b1;
		end
		if (!resetn) begin
			take_d = '0;
		end
	end

	always_ff @(posedge clk) begin
		take_q <= take_d;
	end

	//****************************************************************
	// Status pins
	//****************************************************************
	cbirq_status_t status_q;
	cbirq_status_t status_d;
	logic [1:0]    code;

	// Halt outranks wait; vector acknowledge only while running
	always_comb begin
		if (core.halted) begin
			code = CODE_HALT;
		end else if (core.waiting) begin
			code = CODE_WAIT;
		end else if (core.vector_fetch) begin
			code = CODE_VECTOR;
		end else begin
			code = CODE_RUNNING;
		end
		status_d.bus_granted = code[1];
		status_d.state_code  = code[0];
		// Multi push and pop never lock the bus, even on pair bytes
		status_d.atomic_hold = (core.rmw_cycle || core.first_of_pair
			|| core.first_of_vector) && !core.multi_push_pull;
		status_d.next_cycle_bus_use = core.uses_bus_next
			&& !core.halted && !core.waiting;
		status_d.final_op_cycle = core.last_cycle
			|| (core.halted && core.instr_boundary)
			|| core.waiting || core.stacking;
		if (!resetn) begin
			status_d = '0;
		end
	end

	always_ff @(posedge clk) begin
		status_q <= status_d;
	end

	//****************************************************************
	// Address, direction and read data
	//****************************************************************
	logic [ADDR_W-1:0] addr_q;
	logic [ADDR_W-1:0] addr_d;
	logic              rw_q;
	logic              rw_d;
	logic [DATA_W-1:0] rdata_q;
	logic [DATA_W-1:0] rdata_d;
	logic              rvalid_q;
	logic              rvalid_d;
	logic [DATA_W-1:0] wdata_q;
	logic [DATA_W-1:0] wdata_d;

	// Everything moves on the lagging clock fall, the bus cycle boundary
	always_comb begin
		addr_d   = addr_q;
		rw_d     = rw_q;
		rdata_d  = rdata_q;
		wdata_d  = wdata_q;
		rvalid_d = 1'b0;
		if (b_fall) begin
			if (rw_q) begin
				rdata_d  = data_s;
				rvalid_d = 1'b1;
			end
			addr_d  = core.addr;
			rw_d    = !core.write;
			wdata_d = core.wdata;
		end
		if (!resetn) begin
			addr_d   = ADDR_RST;
			rw_d     = 1'b1;
			rdata_d  = DATA_RST;
			wdata_d  = DATA_RST;
			rvalid_d = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		addr_q   <= addr_d;
		rw_q     <= rw_d;
		rdata_q  <= rdata_d;
		rvalid_q <= rvalid_d;
		wdata_q  <= wdata_d;
	end

	//****************************************************************
	// Bus float control
	//****************************************************************
	logic float_lat_q;
	logic float_lat_d;
	logic wdrive_q;
	logic wdrive_d;
	logic aoe_n_q;
	logic aoe_n_d;
	logic doe_n_q;
	logic doe_n_d;

	// The float request is also caught at the lagging rise and held
	always_comb begin
		float_lat_d = float_lat_q;
		wdrive_d    = wdrive_q;
		if (b_rise && float_s) begin
			float_lat_d = 1'b1;
		end
		if (b_fall) begin
			float_lat_d = 1'b0;
			wdrive_d    = 1'b0;
		end
		// Write data only starts at the leading rise, and only if not floated
		if (a_rise && !rw_q && !float_s) begin
			wdrive_d = 1'b1;
		end
		// Address and direction follow the float pin straight through
		aoe_n_d = float_s || float_lat_q;
		doe_n_d = !wdrive_q || float_s || float_lat_q;
		if (!resetn) begin
			float_lat_d = 1'b0;
			wdrive_d    = 1'b0;
			aoe_n_d     = 1'b1;
			doe_n_d     = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		float_lat_q <= float_lat_d;
		wdrive_q    <= wdrive_d;
		aoe_n_q     <= aoe_n_d;
		doe_n_q     <= doe_n_d;
	end

	//****************************************************************
	// Outputs, all from flip-flops
	//****************************************************************
	// Status keeps driving regardless of float
	assign take            = take_q;
	assign status          = status_q;
	assign read_data       = rdata_q;
	assign read_data_valid = rvalid_q;
	assign addr_out        = addr_q;
	assign addr_oe_n       = aoe_n_q;
	assign rd_wr_out       = rw_q;
	assign rd_wr_oe_n      = aoe_n_q;
	assign data_out        = wdata_q;
	assign data_oe_n       = doe_n_q;
endmodule

// ### testbench/cbirq_props.sv
// Concurrent checks on the bus status and interrupt intake ports
`timescale 1ns/1ns
module cbirq_props
	import cbirq_pkg::*;
(
	input wire logic                     clk,
	input wire logic                     resetn,
	input wire logic                     bus_float_ctl,
	input wire cbirq_pkg::cbirq_core_t   core,
	input wire cbirq_pkg::cbirq_take_t   take,
	input wire cbirq_pkg::cbirq_status_t status,
	input wire logic                     read_data_valid,
	input wire logic                     rd_wr_out,
	input wire logic                     addr_oe_n,
	input wire logic                     rd_wr_oe_n,
	input wire logic                     data_oe_n
);
	import cbirq_pkg::*;
	logic armed_q;
	logic armed_d;
	// Sticky copy of the stack pointer load; one cycle late is harmless
	always_comb begin
		armed_d = armed_q | core.stack_ptr_loaded;
	end
	always_ff @(posedge clk) begin
		if (!resetn) begin
			armed_q <= 1'b0;
		end else begin
			armed_q <= armed_d;
		end
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);
	a_take_boundary: assert property (take.take |-> $past(core.instr_boundary))
		else $error("take outside a boundary");
	a_nmi_full: assert property (take.take && take.kind == IRQ_NMI
		|-> armed_q && take.push_full && take.set_quick_mask)
		else $error("bad nmi take");
	a_fast_part: assert property (take.take && take.kind == IRQ_FAST
		|-> !$past(core.quick_mask) && !take.push_full)
		else $error("bad fast take");
	a_normal_full: assert property (take.take && take.kind == IRQ_NORMAL
		|-> !$past(core.normal_mask) && take.push_full && !take.set_quick_mask)
		else $error("bad normal take");
	a_atomic_set: assert property ((core.rmw_cycle || core.first_of_pair
		|| core.first_of_vector) && !core.multi_push_pull |=> status.atomic_hold)
		else $error("atomic hold missing");
	a_atomic_multi: assert property (core.multi_push_pull |=> !status.atomic_hold)
		else $error("atomic hold in multi push");
	a_bus_use_idle: assert property (core.halted || core.waiting
		|=> !status.next_cycle_bus_use)
		else $error("bus use while idle");
	a_final_cycle: assert property (core.last_cycle || core.waiting
		|| core.stacking |=> status.final_op_cycle)
		else $error("final cycle flag missing");
	a_halt_code: assert property (core.halted
		|=> {status.bus_granted, status.state_code} == CODE_HALT)
		else $error("halt code wrong");
	a_float_release: assert property (bus_float_ctl [*5]
		|-> addr_oe_n && rd_wr_oe_n && data_oe_n)
		else $error("bus driven while floated");
	a_read_capture: assert property (read_data_valid |-> $past(rd_wr_out))
		else $error("capture in a write cycle");
	c_fast: cover property (take.take && take.kind == IRQ_FAST);
	c_nmi: cover property (take.take && take.kind == IRQ_NMI);
	c_read: cover property (read_data_valid);
endmodule

bind cbirq_top cbirq_props u_props (
	.clk(clk), .resetn(resetn), .bus_float_ctl(bus_float_ctl), .core(core),
	.take(take), .status(status), .read_data_valid(read_data_valid),
	.rd_wr_out(rd_wr_out), .addr_oe_n(addr_oe_n), .rd_wr_oe_n(rd_wr_oe_n),
	.data_oe_n(data_oe_n)
);

// ### testbench/cbirq_far_model.sv
// Far side model: quadrature bus clocks and a simple memory
`timescale 1ns/1ns
module cbirq_far_model
	import cbirq_pkg::*;
(
	input  wire logic                         clk,
	input  wire logic [cbirq_pkg::ADDR_W-1:0] addr_out,
	input  wire logic                         addr_oe_n,
	input  wire logic                         rd_wr_out,
	output logic                              clk_ph_a,
	output logic                              clk_ph_b,
	output logic [cbirq_pkg::DATA_W-1:0]      data_in
);
	logic [3:0]        ph_q = 4'h0;
	logic [DATA_W-1:0] last_q = 8'h00;
	// Sixteen clocks per bus cycle; clocks run free, as a real source does
	always @(posedge clk) begin
		ph_q <= ph_q + 4'h1;
		last_q <= data_in;
	end
	// Leading clock rises and falls four clocks before the lagging one
	assign clk_ph_a = ~ph_q[3];
	assign clk_ph_b = ph_q[3] ^ ph_q[2];
	// Unselected bus toggles so a stale byte can never pass for data
	assign data_in = (!addr_oe_n && rd_wr_out) ? addr_out[7:0] ^ 8'hA5 : ~last_q;
endmodule

// ### testbench/tb_cpu_bus_control_and_irq_intake.sv
// Self-checking bench for the bus control and interrupt intake block
`timescale 1ns/1ns
module tb_cpu_bus_control_and_irq_intake;
	import cbirq_pkg::*;
	logic          clk, resetn, clk_ph_a, clk_ph_b, nmi_n, fast_n, norm_n, flt;
	logic          rdv, aoe_n, rw, rwoe_n, doe_n;
	logic [7:0]    din, rd, dout;
	logic [15:0]   ao;
	cbirq_core_t   core;
	cbirq_take_t   tk;
	cbirq_status_t sts;
	int            miscompares = 0;
	int            checks = 0;

	cbirq_top uut (.clk(clk), .resetn(resetn), .clk_ph_a(clk_ph_a), .clk_ph_b(clk_ph_b),
		.nonmaskable_request_n(nmi_n), .fast_request_n(fast_n), .normal_request_n(norm_n),
		.bus_float_ctl(flt), .data_in(din), .core(core), .take(tk), .status(sts),
		.read_data(rd), .read_data_valid(rdv), .addr_out(ao), .addr_oe_n(aoe_n),
		.rd_wr_out(rw), .rd_wr_oe_n(rwoe_n), .data_out(dout), .data_oe_n(doe_n));
	cbirq_far_model far (.clk(clk), .addr_out(ao), .addr_oe_n(aoe_n), .rd_wr_out(rw),
		.clk_ph_a(clk_ph_a), .clk_ph_b(clk_ph_b), .data_in(din));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	task automatic print_verdict();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic chk(input logic ok, input string m);
		checks++;
		if (ok !== 1'b1) begin
			miscompares++;
			$display("BAD %0t %s", $time, m);
		end
	endtask
	// Inputs always move the same 2 ns after an edge, away from sampling
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask
	// A wait that runs out ends the run at once
	task automatic bound(input int i, input string m);
		chk(i < 40, m);
		if (i >= 40) print_verdict();
	endtask
	// Waits for the chosen bus clock pin to go to the other level, then to reach level v
	task automatic wpin(input logic b, input logic v);
		int i;
		for (i = 0; i < 40 && (b ? clk_ph_b : clk_ph_a) !== !v; i++) cyc(1);
		bound(i, "bus clock stuck");
		for (i = 0; i < 40 && (b ? clk_ph_b : clk_ph_a) !== v; i++) cyc(1);
		bound(i, "bus clock stuck");
	endtask
	task automatic wrv();
		int i;
		for (i = 0; i < 40 && rdv !== 1'b1; i++) cyc(1);
		bound(i, "no read strobe");
		cyc(1);
	endtask
	// Kind none means no take may come in forty clocks, two and a half bus cycles
	task automatic wtake(input cbirq_kind_t k, input logic f, input string m);
		int i;
		for (i = 0; i < 40 && tk.take !== 1'b1; i++) cyc(1);
		if (k == IRQ_NONE) begin
			chk(i == 40, m);
		end else begin
			bound(i, m);
			chk(tk.kind === k && tk.push_full === f, m);
			// Only the normal sequence leaves the quick mask alone; all set the normal mask
			chk(tk.set_quick_mask === (k != IRQ_NORMAL) && tk.set_normal_mask === 1'b1, m);
		end
		cyc(1);
	endtask
	task automatic stc(input logic [15:0] f, input logic [4:0] e);
		core[39:24] = f;
		cyc(2);
		chk(sts === e, "status outputs");
	endtask

	task automatic t_status();
		stc(16'h2000, 5'h04);
		stc(16'h1000, 5'h04);
		stc(16'h0800, 5'h04);
		stc(16'h2400, 5'h00);
		stc(16'h0200, 5'h02);
		stc(16'h0300, 5'h18);
		stc(16'h0280, 5'h11);
		stc(16'h8100, 5'h19);
		stc(16'h0040, 5'h01);
		stc(16'h4000, 5'h01);
		stc(16'h0020, 5'h08);
		stc(16'h0000, 5'h00);
	endtask
	// Masks set throughout: the nonmaskable path must ignore them
	task automatic t_nmi();
		core = '0;
		core.instr_boundary = 1'b1;
		core.quick_mask = 1'b1;
		core.normal_mask = 1'b1;
		nmi_n = 1'b0;
		wtake(IRQ_NONE, 1'b0, "nmi before arm");
		nmi_n = 1'b1;
		cyc(20);
		core.stack_ptr_loaded = 1'b1;
		cyc(1);
		nmi_n = 1'b0;
		wtake(IRQ_NMI, 1'b1, "nmi take");
		wtake(IRQ_NONE, 1'b0, "nmi level retrigger");
		nmi_n = 1'b1;
		cyc(20);
	endtask
	task automatic t_prio();
		fast_n = 1'b0;
		norm_n = 1'b0;
		wtake(IRQ_NONE, 1'b0, "masked levels");
		nmi_n = 1'b0;
		wpin(1'b0, 1'b1);
		cyc(5);
		core.quick_mask = 1'b0;
		core.normal_mask = 1'b0;
		wtake(IRQ_NMI, 1'b1, "nmi first");
		wtake(IRQ_FAST, 1'b0, "fast second");
		fast_n = 1'b1;
		wtake(IRQ_NORMAL, 1'b1, "normal last");
		norm_n = 1'b1;
		nmi_n = 1'b1;
		// Software request ranks below every hardware source
		core.soft_request = 1'b1;
		wtake(IRQ_SOFT, 1'b1, "soft after hardware");
		core.soft_request = 1'b0;
		core.instr_boundary = 1'b0;
	endtask
	task automatic t_bus();
		int i;
		int nv;
		int nd;
		core.addr = 16'h1234;
		wrv();
		wrv();
		chk(rd === 8'h91 && ao === 16'h1234 && rw === 1'b1, "read byte");
		core.write = 1'b1;
		core.wdata = 8'h5A;
		wrv();
		chk(doe_n === 1'b1 && rw === 1'b0, "early write data");
		nv = 0;
		nd = 0;
		for (i = 0; i < 18; i++) begin
			cyc(1);
			nv += int'(rdv === 1'b1);
			nd += int'(doe_n === 1'b0 && dout === 8'h5A);
		end
		chk(nv == 0 && nd > 0, "write cycle");
		core.write = 1'b0;
	endtask
	task automatic t_float();
		core.uses_bus_next = 1'b1;
		wpin(1'b1, 1'b0);
		// Arbiter only takes the bus when no locked sequence is running
		chk(sts.atomic_hold === 1'b0, "grant during locked cycle");
		flt = 1'b1;
		cyc(6);
		chk(aoe_n === 1'b1 && rwoe_n === 1'b1 && doe_n === 1'b1, "float");
		chk(sts.next_cycle_bus_use === 1'b1, "status kept");
		flt = 1'b0;
		cyc(4);
		chk(aoe_n === 1'b0 && rwoe_n === 1'b0, "direct float");
		wpin(1'b1, 1'b0);
		flt = 1'b1;
		wpin(1'b1, 1'b1);
		cyc(5);
		flt = 1'b0;
		cyc(4);
		chk(aoe_n === 1'b1, "latched float");
		cyc(4);
		chk(aoe_n === 1'b0, "latch cleared");
	endtask

	initial begin
		resetn = 1'b0;
		nmi_n = 1'b1;
		fast_n = 1'b1;
		norm_n = 1'b1;
		flt = 1'b0;
		core = '0;
		cyc(4);
		resetn = 1'b1;
		cyc(4);
		t_status();
		t_nmi();
		t_prio();
		t_bus();
		t_float();
		print_verdict();
	end
endmodule
